//--- src/tdmcr_pkg.sv
// Package of register map, field layouts and codes for the TDM stream configuration registers
package tdmcr_pkg;
   // ****************************************
   // Address map
   // ****************************************
   localparam int ADDR_W = 14;
   localparam logic [13:0] OFF_CONTROL = 14'h0000;
   localparam logic [13:0] OFF_RATE = 14'h0008;
   localparam logic [13:0] OFF_OVERCAP = 14'h0010;
   localparam logic [13:0] OFF_IN_BASE = 14'h0100;
   localparam logic [13:0] OFF_OUT_BASE = 14'h0200;
   localparam logic [13:0] BANK_MASK = 14'h3FF0;
   localparam int MEM_SEL_BIT = 13;
   localparam int ZERO_BIT = 12;
   localparam int STREAMS = 16;
   // ****************************************
   // Field layouts
   // ****************************************
   localparam logic [15:0] RATE_MASK = 16'h000F;
   localparam logic [15:0] CTRL_MASK = 16'h03FF;
   localparam logic [15:0] IN_MASK = 16'h01F1;
   localparam logic [15:0] OUT_MASK = 16'h01F1;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [15:0] RD_ZERO = 16'h0000;
   // ****************************************
   // Rate codes and memory selections
   // ****************************************
   localparam logic [3:0] RATE_RSVD = 4'h0;
   localparam logic [3:0] RATE_2M = 4'h1;
   localparam logic [3:0] RATE_4M = 4'h2;
   localparam logic [3:0] RATE_8M = 4'h3;
   localparam logic [3:0] RATE_16M = 4'h4;
   localparam logic [1:0] MSEL_CM_LOW = 2'h0;
   localparam logic [1:0] MSEL_DATA = 2'h2;
   localparam logic [1:0] MSEL_CM_HIGH = 2'h3;
   localparam logic [7:0] CH_MAX_2M = 8'h1F;
   localparam logic [7:0] CH_MAX_4M = 8'h3F;
   localparam logic [7:0] CH_MAX_8M = 8'h7F;
   localparam logic [7:0] CH_MAX_16M = 8'hFF;
   // Sampling point and fraction in quarter bits (0..3 means 1/4..4/4 for sampling)
   localparam logic [1:0] Q1 = 2'h0;
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q3 = 2'h2;
   localparam logic [1:0] Q4 = 2'h3;
   localparam logic [1:0] ADV_0 = 2'h0;
   localparam logic [1:0] ADV_1Q = 2'h1;
   localparam logic [1:0] ADV_2Q = 2'h2;
   localparam logic [1:0] ADV_3Q = 2'h3;
endpackage

//--- src/tdmcr_stream_decode.sv
// Decoder of one stream's input and output control words into timing settings
`timescale 1ns/1ns
module tdmcr_stream_decode
   import tdmcr_pkg::*;
(
   // Configuration
   input wire logic [3:0] rate_in,
   input wire logic [15:0] in_word_in,
   input wire logic [15:0] out_word_in,
   // Decoded settings
   output logic [2:0] in_bit_delay_out,
   output logic [1:0] in_sample_point_out,
   output logic in_stream_enable_out,
   output logic [2:0] out_bit_advance_out,
   output logic [1:0] out_fraction_advance_out,
   output logic out_fraction_rsvd_out,
   output logic out_stream_enable_out
);
   logic fast;
   // Decode fields, with the fast rate remapping
   always_comb begin
      fast = (rate_in == RATE_16M);
      in_bit_delay_out = in_word_in[8:6];
      in_stream_enable_out = in_word_in[0];
      out_bit_advance_out = out_word_in[6:4];
      out_stream_enable_out = out_word_in[0];
      out_fraction_rsvd_out = 1'b0;
      if (fast) begin
         in_sample_point_out = in_word_in[5] ? Q4 : Q2;
         out_fraction_advance_out = ADV_0;
         if (out_word_in[8]) begin
            out_fraction_rsvd_out = 1'b1;
         end else if (out_word_in[7]) begin
            out_fraction_advance_out = ADV_2Q;
         end
      end else begin
         case (in_word_in[5:4])
            2'h0: in_sample_point_out = Q3;
            2'h1: in_sample_point_out = Q1;
            2'h2: in_sample_point_out = Q2;
            default: in_sample_point_out = Q4;
         endcase
         out_fraction_advance_out = out_word_in[8:7];
      end
   end
endmodule

//--- src/tdmcr_regs.sv
// Configuration and status register bank of the TDM stream switch
// How it works
// - Four-bit rate code picks one common rate; zero reserved, then 2, 4, 8, 16 Mbps up.
// - Read-only flag word, bit 0 set while channels overprogrammed, clears itself.
// - Each input stream delayed by its three-bit delay field, zero to seven bits.
// - Lower rates: sample code 00=3/4, 01=1/4, 10=2/4, 11=4/4 of bit cell.
// - Fastest rate: lower sample codes give 1/2 point, upper codes give 4/4.
// - Input stream data accepted only while its enable bit is set.
// - Fraction advance 0..3/4 bit; fastest rate 00=0, 01=2/4, rest reserved.
// - Each output stream advanced by its three-bit whole-bit field, zero to seven.
// - Output stream drives only while enabled, else high impedance.
// - Top address bit high routes the access to memory, not registers.
// - Memory select field in control bits 1..0 picks data or connection memory.
// - Memory address bits 11..8 give stream, 7..0 channel; bit 12 zero.
// - Highest valid channel number follows the rate: 31, 63, 127, 255.
`timescale 1ns/1ns
module tdmcr_regs
   import tdmcr_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic soft_reset_in,
   // Host port, one access strobe per cycle
   input wire logic cs_in,
   input wire logic wr_in,
   input wire logic [13:0] addr_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] rdata_out,
   output logic ack_out,
   // Memory-space access steering
   output logic mem_dm_sel_out,
   output logic mem_cml_sel_out,
   output logic mem_cmh_sel_out,
   output logic [3:0] mem_stream_out,
   output logic [7:0] mem_channel_out,
   output logic mem_bad_out,
   // Status from switch core
   input wire logic overprogram_in,
   // Per-stream settings
   output logic [3:0] rate_code_out,
   output logic [7:0] max_channel_out,
   output logic [47:0] in_bit_delay_out,
   output logic [31:0] in_sample_point_out,
   output logic [15:0] in_stream_enable_out,
   output logic [47:0] out_bit_advance_out,
   output logic [31:0] out_fraction_advance_out,
   output logic [15:0] out_fraction_rsvd_out,
   output logic [15:0] out_stream_enable_out,
   // Serial stream gating
   input wire logic [15:0] serial_in,
   output logic [15:0] serial_in_gated_out,
   input wire logic [15:0] serial_out_data_in,
   output logic [15:0] serial_out_lines_out,
   output logic [15:0] serial_out_oen_out
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [15:0] ctrl;
      logic [3:0] rate;
      logic flag;
      logic [15:0][15:0] inw;
      logic [15:0][15:0] outw;
      logic [15:0] rdata;
      logic ack;
      logic dm;
      logic cml;
      logic cmh;
      logic [3:0] strm;
      logic [7:0] chan;
      logic bad;
      logic [7:0] maxch;
      logic [15:0] sin;
      logic [15:0] sout;
      logic [15:0] soen;
      logic [47:0] in_dly;
      logic [31:0] in_smp;
      logic [15:0] in_en;
      logic [47:0] out_adv;
      logic [31:0] out_frac;
      logic [15:0] out_rsv;
      logic [15:0] out_en;
   } tdmcr_state_t;

   tdmcr_state_t s_q, s_d;
   logic [2:0] bd [STREAMS];
   logic [1:0] sp [STREAMS];
   logic [2:0] ba [STREAMS];
   logic [1:0] fa [STREAMS];
   logic [STREAMS-1:0] ien, oen, frsv;
   logic [47:0] bd_v, ba_v;
   logic [31:0] sp_v, fa_v;

   // Bank membership test, used for both banks
   function automatic logic in_bank(input logic [13:0] a, input logic [13:0] base);
      in_bank = ((a & BANK_MASK) == base);
   endfunction

   // ****************************************
   // Per-stream decoders
   // ****************************************
   for (genvar i = 0; i < STREAMS; i++) begin : g_str
      tdmcr_stream_decode u_dec (
         .rate_in(s_q.rate),
         .in_word_in(s_q.inw[i]),
         .out_word_in(s_q.outw[i]),
         .in_bit_delay_out(bd[i]),
         .in_sample_point_out(sp[i]),
         .in_stream_enable_out(ien[i]),
         .out_bit_advance_out(ba[i]),
         .out_fraction_advance_out(fa[i]),
         .out_fraction_rsvd_out(frsv[i]),
         .out_stream_enable_out(oen[i])
      );
      assign bd_v[3*i +: 3] = bd[i];
      assign sp_v[2*i +: 2] = sp[i];
      assign ba_v[3*i +: 3] = ba[i];
      assign fa_v[2*i +: 2] = fa[i];
   end

   // ****************************************
   // Next state
   // ****************************************
   // Reserved bits are masked on write, so a careless host cannot set them
   always_comb begin
      logic [3:0] idx;
      idx = addr_in[3:0];
      s_d = s_q;
      s_d.ack = 1'b0;
      s_d.dm = 1'b0;
      s_d.cml = 1'b0;
      s_d.cmh = 1'b0;
      s_d.bad = 1'b0;
      s_d.flag = overprogram_in;
      s_d.sin = serial_in & ien;
      s_d.sout = serial_out_data_in & oen;
      s_d.soen = ~oen;
      // Decoded settings are registered, so the core sees them one cycle after the word changes
      s_d.in_dly = bd_v;
      s_d.in_smp = sp_v;
      s_d.in_en = ien;
      s_d.out_adv = ba_v;
      s_d.out_frac = fa_v;
      s_d.out_rsv = frsv;
      s_d.out_en = oen;
      case (s_q.rate)
         RATE_2M: s_d.maxch = CH_MAX_2M;
         RATE_4M: s_d.maxch = CH_MAX_4M;
         RATE_8M: s_d.maxch = CH_MAX_8M;
         RATE_16M: s_d.maxch = CH_MAX_16M;
         default: s_d.maxch = CH_MAX_2M;
      endcase
      if (cs_in) begin
         s_d.ack = 1'b1;
         s_d.rdata = RD_ZERO;
         if (addr_in[MEM_SEL_BIT]) begin
            s_d.strm = addr_in[11:8];
            s_d.chan = addr_in[7:0];
            s_d.bad = addr_in[ZERO_BIT] | (addr_in[7:0] > s_q.maxch);
            case (s_q.ctrl[1:0])
               MSEL_CM_LOW: s_d.cml = 1'b1;
               MSEL_DATA: s_d.dm = 1'b1;
               MSEL_CM_HIGH: s_d.cmh = 1'b1;
               default: s_d.bad = 1'b1;
            endcase
         end else if (wr_in) begin
            if (addr_in == OFF_CONTROL) s_d.ctrl = wdata_in & CTRL_MASK;
            if (addr_in == OFF_RATE) s_d.rate = wdata_in[3:0];
            if (in_bank(addr_in, OFF_IN_BASE)) s_d.inw[idx] = wdata_in & IN_MASK;
            if (in_bank(addr_in, OFF_OUT_BASE)) s_d.outw[idx] = wdata_in & OUT_MASK;
         end else begin
            if (addr_in == OFF_CONTROL) s_d.rdata = s_q.ctrl;
            if (addr_in == OFF_RATE) s_d.rdata = {12'h000, s_q.rate};
            if (addr_in == OFF_OVERCAP) s_d.rdata = {15'h0000, s_q.flag};
            if (in_bank(addr_in, OFF_IN_BASE)) s_d.rdata = s_q.inw[idx];
            if (in_bank(addr_in, OFF_OUT_BASE)) s_d.rdata = s_q.outw[idx];
         end
      end
      if (soft_reset_in) begin
         s_d.ctrl = REG_RESET;
         s_d.rate = RATE_RSVD;
         s_d.inw = '0;
         s_d.outw = '0;
      end
   end

   // Register all state
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_q <= '0;
         s_q.soen <= 16'hFFFF;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign rdata_out = s_q.rdata;
   assign ack_out = s_q.ack;
   assign mem_dm_sel_out = s_q.dm;
   assign mem_cml_sel_out = s_q.cml;
   assign mem_cmh_sel_out = s_q.cmh;
   assign mem_stream_out = s_q.strm;
   assign mem_channel_out = s_q.chan;
   assign mem_bad_out = s_q.bad;
   assign rate_code_out = s_q.rate;
   assign max_channel_out = s_q.maxch;
   assign serial_in_gated_out = s_q.sin;
   assign serial_out_lines_out = s_q.sout;
   assign serial_out_oen_out = s_q.soen;
   assign in_bit_delay_out = s_q.in_dly;
   assign in_sample_point_out = s_q.in_smp;
   assign in_stream_enable_out = s_q.in_en;
   assign out_bit_advance_out = s_q.out_adv;
   assign out_fraction_advance_out = s_q.out_frac;
   assign out_fraction_rsvd_out = s_q.out_rsv;
   assign out_stream_enable_out = s_q.out_en;

   // ****************************************
   // Checks
   // ****************************************
   AST_FLAG_FOLLOWS: assert property (@(posedge clk_in) disable iff (!rstn_in)
      1'b1 |=> s_q.flag == $past(overprogram_in)) else $error("flag does not track overcapacity");
   AST_RATE_WRITE: assert property (@(posedge clk_in) disable iff (!rstn_in)
      cs_in && wr_in && addr_in == OFF_RATE && !soft_reset_in |=> rate_code_out == $past(wdata_in[3:0]))
      else $error("rate write lost");
   AST_MEM_ROUTE: assert property (@(posedge clk_in) disable iff (!rstn_in)
      cs_in && addr_in[MEM_SEL_BIT] |=> (mem_dm_sel_out | mem_cml_sel_out | mem_cmh_sel_out | mem_bad_out))
      else $error("memory access not routed");
   AST_MEM_DATA: assert property (@(posedge clk_in) disable iff (!rstn_in)
      cs_in && addr_in[MEM_SEL_BIT] && s_q.ctrl[1:0] == MSEL_DATA |=> mem_dm_sel_out && !mem_cml_sel_out)
      else $error("data memory not selected");
   AST_MEM_ADDR: assert property (@(posedge clk_in) disable iff (!rstn_in)
      cs_in && addr_in[MEM_SEL_BIT] |=> mem_stream_out == $past(addr_in[11:8]) && mem_channel_out == $past(addr_in[7:0]))
      else $error("stream or channel split wrong");
   AST_IN_GATE: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !ien[0] |=> !serial_in_gated_out[0]) else $error("disabled input passed data");
   AST_OUT_HIZ: assert property (@(posedge clk_in) disable iff (!rstn_in)
      !oen[0] |=> serial_out_oen_out[0] && !serial_out_lines_out[0]) else $error("disabled output driven");
   AST_MAXCH: assert property (@(posedge clk_in) disable iff (!rstn_in)
      s_q.rate == RATE_4M ##1 s_q.rate == RATE_4M |-> max_channel_out == CH_MAX_4M) else $error("channel limit wrong");
   AST_SAMPLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
      s_q.rate == RATE_2M && s_q.inw[0][5:4] == 2'h0 |-> sp[0] == Q3) else $error("sample point wrong");
   AST_FAST_FRAC: assert property (@(posedge clk_in) disable iff (!rstn_in)
      s_q.rate == RATE_16M && s_q.outw[0][8:7] == 2'h1 |-> fa[0] == ADV_2Q) else $error("fast fraction wrong");
   AST_DELAY: assert property (@(posedge clk_in) disable iff (!rstn_in)
      1'b1 |=> in_bit_delay_out[5:3] == $past(s_q.inw[1][8:6]) && out_bit_advance_out[5:3] == $past(s_q.outw[1][6:4]))
      else $error("bit delay field wrong");
endmodule

//--- tb/tdmcr_host_model.sv
// Host processor model issuing single-word accesses on the register port
`timescale 1ns/1ns
module tdmcr_host_model (
   // Clock
   input wire logic clk_in,
   // Host port
   output logic cs_out,
   output logic wr_out,
   output logic [13:0] addr_out,
   output logic [15:0] wdata_out
);
   // Idle bus from time zero
   initial begin
      cs_out = 1'b0;
      wr_out = 1'b0;
      addr_out = 14'h0000;
      wdata_out = 16'h0000;
   end
   // One strobe cycle per access; released address and data lines show the inverse so a stale value never passes
   task automatic access(input logic w, input logic [13:0] a, input logic [15:0] d);
      @(posedge clk_in);
      cs_out <= 1'b1;
      wr_out <= w;
      addr_out <= a;
      wdata_out <= d;
      @(posedge clk_in);
      cs_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
      @(posedge clk_in);
   endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the TDM stream configuration register bank
`timescale 1ns/1ns
module tb_top;
   import tdmcr_pkg::*;
   typedef struct packed {logic mem; logic [11:0] loc; logic [3:0] sel; logic rdchk; logic [15:0] rd;} tdmcr_note_t;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic soft_reset_in = 1'b0;
   logic overprogram_in = 1'b0;
   logic [15:0] serial_in = 16'h0000;
   logic [15:0] serial_out_data_in = 16'h0000;
   logic cs, wr, ack, dm, cml, cmh, bad;
   logic [13:0] addr;
   logic [15:0] wdata, rdata, ien, oenv, iw, ow, si, so;
   logic [3:0] rate, mstream;
   logic [7:0] mchan, maxch;
   logic [47:0] ibd, oba;
   logic [31:0] ismp, ofa;
   logic [15:0] ien_o, ofr, oen_o, gated, lines, oen;
   logic [3:0] sel_tbl [4] = '{4'h2, 4'h8, 4'h1, 4'h4};
   tdmcr_note_t notes [$];
   tdmcr_note_t note;
   int errors = 0;
   int n_checks = 0;
   int seed = 43273;
   // 50 MHz clock
   always #10 clk_in = ~clk_in;
   tdmcr_host_model i_host (.clk_in(clk_in), .cs_out(cs), .wr_out(wr), .addr_out(addr), .wdata_out(wdata));
   tdmcr_regs i_dut (.clk_in(clk_in), .rstn_in(rstn_in), .soft_reset_in(soft_reset_in), .cs_in(cs), .wr_in(wr),
      .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .ack_out(ack), .mem_dm_sel_out(dm),
      .mem_cml_sel_out(cml), .mem_cmh_sel_out(cmh), .mem_stream_out(mstream), .mem_channel_out(mchan),
      .mem_bad_out(bad), .overprogram_in(overprogram_in), .rate_code_out(rate), .max_channel_out(maxch),
      .in_bit_delay_out(ibd), .in_sample_point_out(ismp), .in_stream_enable_out(ien_o), .out_bit_advance_out(oba),
      .out_fraction_advance_out(ofa), .out_fraction_rsvd_out(ofr), .out_stream_enable_out(oen_o),
      .serial_in(serial_in), .serial_in_gated_out(gated), .serial_out_data_in(serial_out_data_in),
      .serial_out_lines_out(lines), .serial_out_oen_out(oen));
   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic cmp(input string what, input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Note the expected answer first, since the acknowledge lands before the task returns
   task automatic acc(input logic w, input logic [13:0] a, input logic [15:0] d, input logic [15:0] rd,
         input logic [3:0] sel);
      notes.push_back('{a[13], a[11:0], sel, !w, rd});
      i_host.access(w, a, d);
   endtask
   // Each acknowledge retires the oldest note; a refused steering only promises the error strobe
   always @(posedge clk_in) begin
      if (ack === 1'b1) begin
         note = notes.pop_front();
         cmp("steer", note.sel[3] ? {12'h000, bad, 3'h0} : {12'h000, bad, cmh, cml, dm}, 16'(note.sel));
         if (note.rdchk) cmp("rdata", rdata, note.rd);
         if (note.mem) cmp("location", {4'h0, mstream, mchan}, {4'h0, note.loc});
      end
   end
   // Decoded settings of stream n, worked out from the words written
   task automatic dec(input int n, input logic fast, input logic [15:0] iw, input logic [15:0] ow);
      logic [1:0] s;
      s = fast ? (iw[5] ? Q4 : Q2) : (iw[5:4] == 2'h0) ? Q3 : (iw[5:4] == 2'h3) ? Q4 : iw[5:4] - 2'h1;
      cmp("in_delay", 16'(ibd[3*n+:3]), 16'(iw[8:6]));
      cmp("in_sample", 16'(ismp[2*n+:2]), 16'(s));
      cmp("in_enable", 16'(ien_o[n]), 16'(iw[0]));
      cmp("out_advance", 16'(oba[3*n+:3]), 16'(ow[6:4]));
      cmp("out_rsvd", 16'(ofr[n]), 16'(fast & ow[8]));
      if (!(fast && ow[8])) cmp("out_fraction", 16'(ofa[2*n+:2]), fast ? {14'h0, ow[7], 1'b0} : 16'(ow[8:7]));
      cmp("out_enable", 16'(oen_o[n]), 16'(ow[0]));
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Watchdog well beyond the thousand or so cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_in);
      errors++;
      summarize();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (6) @(posedge clk_in);
      rstn_in <= 1'b1;
      @(negedge clk_in);
      cmp("oen_reset", oen, 16'hFFFF);
      for (int n = 0; n < STREAMS; n++) begin
         acc(1'b0, OFF_IN_BASE + 14'(n), 16'h0000, REG_RESET, 4'h0);
         acc(1'b0, OFF_OUT_BASE + 14'(n), 16'h0000, REG_RESET, 4'h0);
      end
      $display("test reset_values done");
      // Rate codes 1 to 4, with random stream words under each
      for (int r = 1; r <= 4; r++) begin
         acc(1'b1, OFF_RATE, 16'(r), 16'h0000, 4'h0);
         acc(1'b0, OFF_RATE, 16'h0000, 16'(r), 4'h0);
         cmp("max_channel", 16'(maxch), 16'((32 << (r - 1)) - 1));
         cmp("rate_code", 16'(rate), 16'(r));
         for (int n = 0; n < STREAMS; n++) begin
            iw = 16'($random(seed)) & IN_MASK;
            ow = 16'($random(seed)) & OUT_MASK;
            // Stream 0 pins the codes that the sampling and fast-fraction checks watch
            if (n == 0) iw[5:4] = 2'h0;
            if (n == 0) ow[8:7] = 2'h1;
            ien[n] = iw[0];
            oenv[n] = ow[0];
            acc(1'b1, OFF_IN_BASE + 14'(n), iw, 16'h0000, 4'h0);
            acc(1'b1, OFF_OUT_BASE + 14'(n), ow, 16'h0000, 4'h0);
            acc(1'b0, OFF_IN_BASE + 14'(n), 16'h0000, iw, 4'h0);
            acc(1'b0, OFF_OUT_BASE + 14'(n), 16'h0000, ow, 4'h0);
            @(negedge clk_in);
            dec(n, r == 4, iw, ow);
         end
      end
      $display("test stream_words done");
      // Serial gating with the enables left by the last rate
      si = 16'($random(seed));
      so = 16'($random(seed));
      @(posedge clk_in);
      serial_in <= si;
      serial_out_data_in <= so;
      repeat (2) @(posedge clk_in);
      @(negedge clk_in);
      cmp("in_gated", gated, si & ien);
      cmp("out_lines", lines, so & oenv);
      cmp("out_oen", oen, ~oenv);
      $display("test serial_gating done");
      // Flag follows the core, ignores writes and clears itself
      @(posedge clk_in);
      overprogram_in <= 1'b1;
      acc(1'b1, OFF_OVERCAP, 16'h0000, 16'h0000, 4'h0);
      acc(1'b0, OFF_OVERCAP, 16'h0000, 16'h0001, 4'h0);
      overprogram_in <= 1'b0;
      acc(1'b0, OFF_OVERCAP, 16'h0000, 16'h0000, 4'h0);
      acc(1'b0, 14'h0020, 16'h0000, RD_ZERO, 4'h0);
      $display("test flag done");
      // Memory steering under every select code
      acc(1'b1, OFF_RATE, 16'(RATE_2M), 16'h0000, 4'h0);
      for (int m = 0; m < 4; m++) begin
         acc(1'b1, OFF_CONTROL, 16'(m), 16'h0000, 4'h0);
         acc(1'b0, OFF_CONTROL, 16'h0000, 16'(m), 4'h0);
         acc(1'b0, 14'h2000 | (14'($random(seed)) & 14'h0F1F), 16'h0000, 16'h0000, sel_tbl[m]);
      end
      acc(1'b0, 14'h3000, 16'h0000, 16'h0000, 4'h8);
      acc(1'b0, 14'h2020, 16'h0000, 16'h0000, 4'h8);
      acc(1'b1, 14'h2008, 16'h000F, 16'h0000, 4'h4);
      acc(1'b0, OFF_RATE, 16'h0000, 16'(RATE_2M), 4'h0);
      $display("test memory_steering done");
      // Soft reset clears the words
      soft_reset_in <= 1'b1;
      @(posedge clk_in);
      soft_reset_in <= 1'b0;
      acc(1'b0, OFF_RATE, 16'h0000, REG_RESET, 4'h0);
      acc(1'b0, OFF_CONTROL, 16'h0000, REG_RESET, 4'h0);
      acc(1'b0, OFF_IN_BASE + 14'h000F, 16'h0000, REG_RESET, 4'h0);
      acc(1'b0, OFF_OUT_BASE + 14'h000F, 16'h0000, REG_RESET, 4'h0);
      $display("test soft_reset done");
      repeat (3) @(posedge clk_in);
      summarize();
   end
endmodule
